/* File: bench/remote_host.sv */
`timescale 1ns/10ps
module remote_host (
  input wire logic CLK,
  output scan_cmd_pkg::rx_type IEEE_IN,
  input wire logic IEEE_READY,
  output scan_cmd_pkg::rx_type SER_IN,
  input wire logic SER_READY
);
  initial begin
    IEEE_IN = '0;
    SER_IN = '0;
  end
  // ----------------------------------------
  // Byte transfer, held until taken
  // ----------------------------------------
  task automatic put(input bit ser, input logic atn, input logic [7:0] d, inout int errs);
    int n;
    n = 0;
    @(negedge CLK);
    if (ser) SER_IN = '{1'b1, 1'b0, d};
    else IEEE_IN = '{1'b1, atn, d};
    // Ready is looked at mid-cycle, where it stands until the taking edge
    while (!(ser ? SER_READY : IEEE_READY) && n < 400) begin
      n++;
      @(negedge CLK);
    end
    if (n >= 400) errs++;
    @(posedge CLK);
    @(negedge CLK);
    // Released lines must not keep the old byte
    if (ser) SER_IN = '{1'b0, 1'b1, ~d};
    else IEEE_IN = '{1'b0, ~atn, ~d};
  endtask
  // Block address digits come before the command digit
  // Boundaries sent in four-wire mode are loaded as sent, odd blocks included
endmodule

/* File: bench/switch_scan_cmd_asserts.sv */
`timescale 1ns/10ps
module switch_scan_cmd_asserts (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire scan_cmd_pkg::rx_type IEEE_IN,
  input wire logic IEEE_READY,
  input wire scan_cmd_pkg::rx_type SER_IN,
  input wire logic SER_READY,
  input wire logic AUTOSCAN_SW,
  input wire logic [4:0] LISTEN_ADDR_SW,
  input wire scan_cmd_pkg::scan_out_type SCAN_OUT,
  input wire logic REMOTE_LAMP,
  input wire logic KEYPAD_LOCK,
  input wire logic LISTENING
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  logic uc_taken;
  assign uc_taken = IEEE_IN.valid && IEEE_READY && IEEE_IN.atn;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  chk_autoscan_stall: assert property (AUTOSCAN_SW [*4] |-> !IEEE_READY && !SER_READY)
    else $error("ready high during autoscan");
  chk_break_make: assert property (SCAN_OUT.closed && $past(SCAN_OUT.closed) |-> $stable(SCAN_OUT.chan))
    else $error("channel changed while closed");
  chk_pair_even: assert property (SCAN_OUT.pair |-> SCAN_OUT.closed && ((SCAN_OUT.chan / 10'h00a) % 2) == 0)
    else $error("pair on odd block");
  chk_chan_range: assert property (SCAN_OUT.closed |-> SCAN_OUT.chan <= scan_cmd_pkg::ADDR_MAX)
    else $error("channel out of range");
  chk_own_address: assert property (uc_taken && LISTEN_ADDR_SW <= scan_cmd_pkg::LISTEN_ADDR_MAX
      && IEEE_IN.data[6:0] == (scan_cmd_pkg::UC_LISTEN_BASE | {2'b00, LISTEN_ADDR_SW})
      |=> LISTENING && REMOTE_LAMP)
    else $error("listen address not entered");
  chk_unlisten_only: assert property ($fell(LISTENING) |->
      $past(uc_taken && IEEE_IN.data[6:0] == scan_cmd_pkg::UC_UNLISTEN))
    else $error("listening dropped without unlisten");
  chk_lockout_set: assert property (uc_taken && IEEE_IN.data[6:0] == scan_cmd_pkg::UC_LOCKOUT |=> KEYPAD_LOCK)
    else $error("lockout not set");
  chk_serial_remote: assert property (SER_IN.valid && SER_READY |=> REMOTE_LAMP)
    else $error("serial byte left local");
  cov_pair: cover property (SCAN_OUT.pair);
  cov_close: cover property ($rose(SCAN_OUT.closed));
  cov_unlisten: cover property ($fell(LISTENING));
endmodule
bind switch_scan_cmd switch_scan_cmd_asserts switch_scan_cmd_asserts_inst (.CLK(CLK), .ARST_N(ARST_N),
  .IEEE_IN(IEEE_IN), .IEEE_READY(IEEE_READY), .SER_IN(SER_IN), .SER_READY(SER_READY),
  .AUTOSCAN_SW(AUTOSCAN_SW), .LISTEN_ADDR_SW(LISTEN_ADDR_SW), .SCAN_OUT(SCAN_OUT),
  .REMOTE_LAMP(REMOTE_LAMP), .KEYPAD_LOCK(KEYPAD_LOCK), .LISTENING(LISTENING));

/* File: bench/switch_scan_cmd_test.sv */
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("Error at %0t: got %0h expected %0h", $time, (a), (b)); end end
module switch_scan_cmd_test;
  logic CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic FOUR_WIRE_SW = 1'b0;
  logic AUTOSCAN_SW = 1'b0;
  logic LOCAL_KEY = 1'b0;
  logic [4:0] LISTEN_ADDR_SW = 5'h05;
  scan_cmd_pkg::mod_type_type TYPE_CODE = scan_cmd_pkg::MOD_GENERAL;
  scan_cmd_pkg::rx_type IEEE_IN, SER_IN;
  scan_cmd_pkg::scan_out_type SCAN_OUT;
  scan_cmd_pkg::latch_out_type LATCH_OUT;
  logic IEEE_READY, SER_READY, ERR_SHOW, REMOTE_LAMP, KEYPAD_LOCK, LISTENING;
  logic [6:0] TYPE_BLOCK;
  logic [7:0] last_bits = 8'h00;
  logic [6:0] last_block = 7'h00;
  logic [11:0] DISPLAY_BCD;
  logic DISPLAY_BLANK;
  int errors = 0;
  int cmp_count = 0;
  always #12.5 CLK = ~CLK;
  switch_scan_cmd switch_scan_cmd_inst (.CLK(CLK), .ARST_N(ARST_N), .IEEE_IN(IEEE_IN),
    .IEEE_READY(IEEE_READY), .SER_IN(SER_IN), .SER_READY(SER_READY), .FOUR_WIRE_SW(FOUR_WIRE_SW),
    .AUTOSCAN_SW(AUTOSCAN_SW), .LOCAL_KEY(LOCAL_KEY), .LISTEN_ADDR_SW(LISTEN_ADDR_SW),
    .TYPE_BLOCK(TYPE_BLOCK), .TYPE_CODE(TYPE_CODE), .SCAN_OUT(SCAN_OUT), .LATCH_OUT(LATCH_OUT),
    .DISPLAY_BCD(DISPLAY_BCD), .DISPLAY_BLANK(DISPLAY_BLANK), .ERR_SHOW(ERR_SHOW), .REMOTE_LAMP(REMOTE_LAMP),
    .KEYPAD_LOCK(KEYPAD_LOCK), .LISTENING(LISTENING));
  remote_host remote_host_inst (.CLK(CLK), .IEEE_IN(IEEE_IN), .IEEE_READY(IEEE_READY),
    .SER_IN(SER_IN), .SER_READY(SER_READY));
  // ----------------------------------------
  // Installed modules: 1 low level, 2/3 four-wire, 5 latching
  // ----------------------------------------
  always @(negedge CLK) begin
    case (TYPE_BLOCK)
      7'h01: TYPE_CODE <= scan_cmd_pkg::MOD_LOW_LEVEL;
      7'h02, 7'h03: TYPE_CODE <= scan_cmd_pkg::MOD_FOUR_WIRE;
      7'h05: TYPE_CODE <= scan_cmd_pkg::MOD_LATCHING;
      default: TYPE_CODE <= scan_cmd_pkg::MOD_GENERAL;
    endcase
  end
  always @(posedge CLK) begin
    if (LATCH_OUT.stb) begin
      last_bits <= LATCH_OUT.bits;
      last_block <= LATCH_OUT.block;
    end
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic settle();
    int n;
    n = 0;
    @(negedge CLK);
    while (!(IEEE_READY && SER_READY) && n < 400) begin
      n++;
      @(negedge CLK);
    end
    if (n >= 400) errors++;
    // One more cycle so the latch capture has landed
    @(negedge CLK);
  endtask
  task automatic press();
    LOCAL_KEY = 1'b1;
    repeat (4) @(negedge CLK);
    LOCAL_KEY = 1'b0;
    repeat (4) @(negedge CLK);
  endtask
  task automatic send(input bit ser, input string s);
    for (int i = 0; i < s.len(); i++) remote_host_inst.put(ser, 1'b0, s[i], errors);
    settle();
  endtask
  task automatic uc(input logic [6:0] c);
    remote_host_inst.put(1'b0, 1'b1, {1'b0, c}, errors);
    settle();
  endtask
  task automatic sel(input bit ser, input string s, input logic [9:0] ch, input logic pr);
    send(ser, s);
    `CHK(SCAN_OUT, {1'b1, pr, ch})
  endtask
  task test_done();
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(25ns * 20000);
    errors++;
    test_done();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (2) @(negedge CLK);
    ARST_N = 1'b1;
    settle();
    `CHK(SCAN_OUT.closed, 1'b0)
    sel(1'b1, "5,", 10'h005, 1'b0);
    `CHK(REMOTE_LAMP, 1'b1)
    sel(1'b1, "12,", 10'h00c, 1'b0);
    `CHK(DISPLAY_BCD, 12'h012)
    FOUR_WIRE_SW = 1'b1;
    repeat (4) @(negedge CLK);
    sel(1'b1, "23,", 10'h017, 1'b1);
    sel(1'b1, "34,", 10'h022, 1'b0);
    FOUR_WIRE_SW = 1'b0;
    send(1'b1, "53,");
    `CHK(last_bits, 8'h08)
    `CHK(last_block, 7'h05)
    send(1'b1, "57,");
    `CHK(last_bits, 8'h88)
    send(1'b1, "58,");
    `CHK(last_bits, 8'h80)
    send(1'b1, "51,");
    `CHK(last_bits, 8'h82)
    send(1'b1, "59,");
    `CHK(last_bits, 8'h02)
    send(1'b1, "R");
    `CHK(last_bits, 8'h00)
    sel(1'b1, "99,+", 10'h000, 1'b0);
    send(1'b1, "7B09B1");
    sel(1'b1, "9,+", 10'h007, 1'b0);
    sel(1'b1, "999,+", 10'h000, 1'b0);
    sel(1'b1, "+", 10'h001, 1'b0);
    send(1'b1, "*,");
    `CHK(SCAN_OUT.closed, 1'b0)
    send(1'b1, "+");
    `CHK(ERR_SHOW, 1'b1)
    uc(7'h25);
    `CHK(LISTENING, 1'b1)
    sel(1'b0, "3,", 10'h003, 1'b0);
    uc(scan_cmd_pkg::UC_LOCKOUT);
    `CHK(KEYPAD_LOCK, 1'b1)
    press();
    `CHK(REMOTE_LAMP, 1'b1)
    uc(scan_cmd_pkg::UC_UNLISTEN);
    sel(1'b0, "4,", 10'h003, 1'b0);
    uc(scan_cmd_pkg::UC_SEL_CLEAR);
    uc(7'h15);
    `CHK(SCAN_OUT, {2'b10, 10'h003})
    uc(7'h25);
    uc(scan_cmd_pkg::UC_SEL_CLEAR);
    `CHK(SCAN_OUT.closed, 1'b0)
    `CHK({DISPLAY_BLANK, DISPLAY_BCD}, 13'h1000)
    sel(1'b0, "6,", 10'h006, 1'b0);
    uc(scan_cmd_pkg::UC_DEV_CLEAR);
    `CHK(SCAN_OUT.closed, 1'b0)
    `CHK({DISPLAY_BLANK, DISPLAY_BCD}, 13'h1000)
    send(1'b1, "L0");
    `CHK(KEYPAD_LOCK, 1'b0)
    press();
    `CHK(REMOTE_LAMP, 1'b0)
    send(1'b1, "L");
    `CHK(KEYPAD_LOCK, 1'b1)
    `CHK(REMOTE_LAMP, 1'b1)
    AUTOSCAN_SW = 1'b1;
    repeat (5) @(negedge CLK);
    `CHK({IEEE_READY, SER_READY}, 2'b00)
    AUTOSCAN_SW = 1'b0;
    settle();
    test_done();
  end
endmodule

/* File: design/relay_store.sv */
`timescale 1ns/10ps
module relay_store (
  input wire logic clk,
  input wire logic we,
  input wire logic [6:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [6:0] raddr,
  output logic [7:0] rdata
);

  // Contents are undefined until the reset walk has cleared them
  logic [7:0] mem [0:99];

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end

endmodule

/* File: design/scan_cmd_pkg.sv */
// Functional notes
// - Scanner command digit closes that channel
// - Closing one scanner channel opens all others
// - Reset opens the closed scanning channel only if it is in the selected block
// - Low level module decodes like general
// - Four-wire even block closes sense and source
// - Odd block closes only source relay
// - Latching commands 0-7 latch relay until opened
// - Latch 8/9 open halves, reset opens all
// - Module command is bb then c
// - Scan boundaries default to 0 and 99
// - Number then floor_set_cmd loads lower boundary
// - Number then ceiling_set_cmd loads upper boundary
// - Plus increments; none selected shows fault
// - Increment wraps upper to lower, 999 to 0
// - IEEE-488 side only listens, never drives
// - Ignore universal commands except five
// - Own listen address enters remote, lamp on
// - Autoscan withholds handshake and remote data
// - Unlisten stops listening until readdressed
// - Local lockout disables whole keypad
// - Device clear resets modules and display
// - Selected clear acts only while listening
// - Serial data enters remote, lamp on
// - Serial freeze locks keypad, keypad_thaw_cmd unlocks
package scan_cmd_pkg;

  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam logic [9:0] LOWER_RESET = 10'h000;
  localparam logic [9:0] UPPER_RESET = 10'h063;
  localparam logic [9:0] ADDR_MAX = 10'h3e7;
  localparam logic [6:0] BLOCK_LAST = 7'h63;
  localparam logic [3:0] CMD_OPEN_LOW = 4'h8;
  localparam logic [3:0] CMD_OPEN_HIGH = 4'h9;
  localparam logic [7:0] KEEP_HIGH = 8'hf0;
  localparam logic [7:0] KEEP_LOW = 8'h0f;
  localparam logic [7:0] CH_0 = 8'h30;
  localparam logic [7:0] CH_1 = 8'h31;
  localparam logic [7:0] CH_9 = 8'h39;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_PLUS = 8'h2b;
  localparam logic [7:0] CH_DOLLAR = 8'h24;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_B = 8'h42;
  localparam logic [7:0] CH_L = 8'h4c;
  localparam logic [6:0] UC_LISTEN_BASE = 7'h20;
  localparam logic [4:0] LISTEN_ADDR_MAX = 5'h1e;
  localparam logic [6:0] UC_UNLISTEN = 7'h3f;
  localparam logic [6:0] UC_LOCKOUT = 7'h11;
  localparam logic [6:0] UC_DEV_CLEAR = 7'h14;
  localparam logic [6:0] UC_SEL_CLEAR = 7'h04;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {MOD_GENERAL, MOD_LOW_LEVEL, MOD_FOUR_WIRE, MOD_LATCHING} mod_type_type;
  typedef enum logic [2:0] {PH_IDLE, PH_LOOK, PH_ACT, PH_BREAK, PH_CLEAR} phase_type;
  typedef enum logic {JOB_SELECT, JOB_BLOCK_RESET} job_type;

  typedef struct packed {
    logic valid;
    logic atn;
    logic [7:0] data;
  } rx_type;

  typedef struct packed {
    logic closed;
    logic pair;
    logic [9:0] chan;
  } scan_out_type;

  typedef struct packed {
    logic stb;
    logic [6:0] block;
    logic [7:0] bits;
  } latch_out_type;

  typedef struct packed {
    logic four_wire;
    logic autoscan;
    logic local_key;
    logic [4:0] addr;
  } pins_type;

  typedef struct packed {
    phase_type phase;
    job_type job;
    logic [9:0] target;
    logic [6:0] walk;
    logic [11:0] bcd;
    logic blank;
    logic num_pend;
    logic [1:0] clr_stage;
    logic after_b;
    logic after_l;
    logic sel_valid;
    logic [9:0] sel_addr;
    logic [9:0] lower;
    logic [9:0] upper;
    scan_out_type scan;
    latch_out_type latch;
    logic listen;
    logic remote;
    logic lockout;
    logic err;
    pins_type pin_a;
    pins_type pin_b;
    logic key_prev;
  } state_type;

endpackage

/* File: design/switch_scan_cmd.sv */
`timescale 1ns/10ps
module switch_scan_cmd (
  input wire logic CLK,
  input wire logic ARST_N,
  input wire scan_cmd_pkg::rx_type IEEE_IN,
  output logic IEEE_READY,
  input wire scan_cmd_pkg::rx_type SER_IN,
  output logic SER_READY,
  input wire logic FOUR_WIRE_SW,
  input wire logic AUTOSCAN_SW,
  input wire logic LOCAL_KEY,
  input wire logic [4:0] LISTEN_ADDR_SW,
  output logic [6:0] TYPE_BLOCK,
  input wire scan_cmd_pkg::mod_type_type TYPE_CODE,
  output scan_cmd_pkg::scan_out_type SCAN_OUT,
  output scan_cmd_pkg::latch_out_type LATCH_OUT,
  output logic [11:0] DISPLAY_BCD,
  output logic DISPLAY_BLANK,
  output logic ERR_SHOW,
  output logic REMOTE_LAMP,
  output logic KEYPAD_LOCK,
  output logic LISTENING
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [9:0] bcd_value(input logic [11:0] b);
    logic [9:0] h;
    logic [9:0] t;
    logic [9:0] u;
    h = {6'h00, b[11:8]};
    t = {6'h00, b[7:4]};
    u = {6'h00, b[3:0]};
    return h * 10'h064 + t * 10'h00a + u;
  endfunction

  function automatic logic [11:0] to_bcd(input logic [9:0] v);
    logic [9:0] h;
    logic [9:0] t;
    logic [9:0] u;
    h = v / 10'h064;
    t = (v / 10'h00a) % 10'h00a;
    u = v % 10'h00a;
    return {h[3:0], t[3:0], u[3:0]};
  endfunction

  scan_cmd_pkg::state_type s_q;
  scan_cmd_pkg::state_type s_d;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [7:0] mem_wdata;
  logic [7:0] mem_rdata;
  logic [9:0] blk_wide;
  logic [9:0] cmd_wide;
  logic [6:0] blk;
  logic [3:0] cmd;
  logic [9:0] scan_blk_wide;
  logic idle;
  logic take_ieee;
  logic take_ser;
  scan_cmd_pkg::rx_type rx;
  logic is_uc;
  logic is_data;
  logic [7:0] c;
  logic [9:0] entry;
  logic [9:0] next_addr;
  logic [7:0] bits;
  logic reset_all;
  logic start_job;
  scan_cmd_pkg::job_type new_job;
  logic [9:0] new_target;
  logic [6:0] uc_code;
  logic uc_mla;
  logic uc_unl;
  logic uc_llo;
  logic uc_dcl;
  logic uc_sdc;

  // ----------------------------------------
  // Decode and handshakes
  // ----------------------------------------
  assign blk_wide = s_q.target / 10'h00a;
  assign cmd_wide = s_q.target % 10'h00a;
  assign blk = blk_wide[6:0];
  assign cmd = cmd_wide[3:0];
  assign scan_blk_wide = s_q.scan.chan / 10'h00a;
  assign idle = s_q.phase == scan_cmd_pkg::PH_IDLE;
  // No new byte while a job runs; autoscan stalls both ports
  assign IEEE_READY = idle && !s_q.pin_b.autoscan;
  assign SER_READY = idle && !s_q.pin_b.autoscan;
  assign take_ieee = IEEE_IN.valid && IEEE_READY;
  assign take_ser = SER_IN.valid && SER_READY && !take_ieee;
  assign rx = take_ieee ? IEEE_IN : SER_IN;
  assign is_uc = take_ieee && IEEE_IN.atn;
  // Addressed data only; unlistened bytes are taken and dropped
  assign is_data = take_ser || (take_ieee && !IEEE_IN.atn && s_q.listen);
  assign c = rx.data;
  assign entry = bcd_value(s_q.bcd);
  assign next_addr = (s_q.sel_addr == s_q.upper) ? s_q.lower :
                     (s_q.sel_addr == scan_cmd_pkg::ADDR_MAX) ? 10'h000 :
                     s_q.sel_addr + 10'h001;
  assign TYPE_BLOCK = blk;

  // ----------------------------------------
  // Universal command decode
  // ----------------------------------------
  // Address 31 would alias the unlisten code, so it never matches
  assign uc_code = c[6:0];
  assign uc_mla = uc_code == (scan_cmd_pkg::UC_LISTEN_BASE | {2'b00, s_q.pin_b.addr}) &&
                  s_q.pin_b.addr <= scan_cmd_pkg::LISTEN_ADDR_MAX;
  assign uc_unl = uc_code == scan_cmd_pkg::UC_UNLISTEN;
  assign uc_llo = uc_code == scan_cmd_pkg::UC_LOCKOUT;
  assign uc_dcl = uc_code == scan_cmd_pkg::UC_DEV_CLEAR;
  assign uc_sdc = uc_code == scan_cmd_pkg::UC_SEL_CLEAR && s_q.listen;

  relay_store store (
    .clk(CLK),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(blk),
    .rdata(mem_rdata)
  );

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    mem_we = 1'b0;
    mem_waddr = s_q.walk;
    mem_wdata = 8'h00;
    bits = mem_rdata;
    reset_all = 1'b0;
    start_job = 1'b0;
    new_job = scan_cmd_pkg::JOB_SELECT;
    new_target = s_q.sel_addr;
    s_d.latch.stb = 1'b0;
    s_d.pin_a = {FOUR_WIRE_SW, AUTOSCAN_SW, LOCAL_KEY, LISTEN_ADDR_SW};
    s_d.pin_b = s_q.pin_a;
    s_d.key_prev = s_q.pin_b.local_key;
    // Local key is dead while the keypad is locked
    if (s_q.pin_b.local_key && !s_q.key_prev && !s_q.lockout) begin
      s_d.remote = 1'b0;
    end
    if (take_ser) begin
      s_d.remote = 1'b1;
    end
    if (take_ieee || take_ser) begin
      s_d.err = 1'b0;
    end
    // Universal commands; anything else under attention is dropped
    if (is_uc) begin
      if (uc_mla) begin
        s_d.listen = 1'b1;
        s_d.remote = 1'b1;
      end else if (uc_unl) begin
        s_d.listen = 1'b0;
      end else if (uc_llo) begin
        s_d.lockout = 1'b1;
      end else if (uc_dcl) begin
        reset_all = 1'b1;
      end else if (uc_sdc) begin
        reset_all = 1'b1;
      end
    end
    if (is_data) begin
      s_d.clr_stage = 2'b00;
      s_d.after_b = 1'b0;
      s_d.after_l = 1'b0;
      if (s_q.after_l && c == scan_cmd_pkg::CH_0) begin
        s_d.lockout = 1'b0;
      end else if (s_q.after_b && (c == scan_cmd_pkg::CH_0 || c == scan_cmd_pkg::CH_1)) begin
        if (c == scan_cmd_pkg::CH_0) begin
          s_d.lower = entry;
        end else begin
          s_d.upper = entry;
        end
        s_d.num_pend = 1'b0;
      end else if (c >= scan_cmd_pkg::CH_0 && c <= scan_cmd_pkg::CH_9) begin
        // Last three digits win; single-digit entries read as block 00
        if (s_q.num_pend) begin
          s_d.bcd = {s_q.bcd[7:0], c[3:0]};
        end else begin
          // A fresh entry starts from 000, so missing block digits read 00
          s_d.bcd = {8'h00, c[3:0]};
        end
        s_d.num_pend = 1'b1;
        s_d.blank = 1'b0;
      end else if (c == scan_cmd_pkg::CH_COMMA) begin
        if (s_q.clr_stage == 2'b01) begin
          reset_all = 1'b1;
          s_d.clr_stage = 2'b10;
        end else if (s_q.clr_stage == 2'b10) begin
          s_d.lower = scan_cmd_pkg::LOWER_RESET;
          s_d.upper = scan_cmd_pkg::UPPER_RESET;
        end else if (s_q.num_pend) begin
          start_job = 1'b1;
          new_target = entry;
          s_d.num_pend = 1'b0;
        end
      end else if (c == scan_cmd_pkg::CH_DOLLAR) begin
        s_d.bcd = 12'h000;
        s_d.blank = 1'b1;
        s_d.num_pend = 1'b0;
        s_d.clr_stage = 2'b01;
      end else if (c == scan_cmd_pkg::CH_STAR) begin
        reset_all = 1'b1;
        s_d.clr_stage = 2'b10;
      end else if (c == scan_cmd_pkg::CH_PLUS) begin
        if (!s_q.sel_valid) begin
          s_d.err = 1'b1;
        end else begin
          start_job = 1'b1;
          new_target = next_addr;
        end
      end else if (c == scan_cmd_pkg::CH_R) begin
        if (!s_q.sel_valid) begin
          s_d.err = 1'b1;
        end else begin
          start_job = 1'b1;
          new_job = scan_cmd_pkg::JOB_BLOCK_RESET;
        end
      end else if (c == scan_cmd_pkg::CH_B) begin
        s_d.after_b = 1'b1;
      end else if (c == scan_cmd_pkg::CH_L && take_ser) begin
        s_d.lockout = 1'b1;
        s_d.after_l = 1'b1;
      end
    end
    if (start_job) begin
      s_d.phase = scan_cmd_pkg::PH_LOOK;
      s_d.job = new_job;
      s_d.target = new_target;
      if (new_job == scan_cmd_pkg::JOB_SELECT) begin
        s_d.sel_valid = 1'b1;
        s_d.sel_addr = new_target;
        // Display follows the channel just selected
        s_d.bcd = to_bcd(new_target);
        s_d.blank = 1'b0;
      end
    end
    if (reset_all) begin
      s_d.bcd = 12'h000;
      s_d.blank = 1'b1;
      s_d.num_pend = 1'b0;
      // Selection is forgotten, so a later increment faults
      s_d.sel_valid = 1'b0;
      s_d.scan.closed = 1'b0;
      s_d.scan.pair = 1'b0;
      s_d.walk = 7'h00;
      s_d.phase = scan_cmd_pkg::PH_CLEAR;
    end
    unique case (s_q.phase)
      scan_cmd_pkg::PH_IDLE: begin
      end
      scan_cmd_pkg::PH_LOOK: begin
        // Relay store read lands one cycle later
        s_d.phase = scan_cmd_pkg::PH_ACT;
      end
      scan_cmd_pkg::PH_ACT: begin
        s_d.phase = scan_cmd_pkg::PH_IDLE;
        if (TYPE_CODE == scan_cmd_pkg::MOD_LATCHING) begin
          if (s_q.job == scan_cmd_pkg::JOB_BLOCK_RESET) begin
            bits = 8'h00;
          end else if (cmd == scan_cmd_pkg::CMD_OPEN_LOW) begin
            bits = mem_rdata & scan_cmd_pkg::KEEP_HIGH;
          end else if (cmd == scan_cmd_pkg::CMD_OPEN_HIGH) begin
            bits = mem_rdata & scan_cmd_pkg::KEEP_LOW;
          end else begin
            bits = mem_rdata | (8'h01 << cmd[2:0]);
          end
          // Relays outside the command keep their latched state
          mem_we = 1'b1;
          mem_waddr = blk;
          mem_wdata = bits;
          s_d.latch.stb = 1'b1;
          s_d.latch.block = blk;
          s_d.latch.bits = bits;
        end else if (s_q.job == scan_cmd_pkg::JOB_BLOCK_RESET) begin
          if (scan_blk_wide[6:0] == blk) begin
            s_d.scan.closed = 1'b0;
            s_d.scan.pair = 1'b0;
          end
        end else begin
          // Open the closed scanning channel, whatever its block; latched relays stay as they are
          s_d.scan.closed = 1'b0;
          s_d.scan.pair = 1'b0;
          s_d.phase = scan_cmd_pkg::PH_BREAK;
        end
      end
      scan_cmd_pkg::PH_BREAK: begin
        // One channel register means at most one scanning channel is ever closed
        s_d.scan.closed = 1'b1;
        s_d.scan.chan = s_q.target;
        s_d.scan.pair = s_q.pin_b.four_wire && TYPE_CODE == scan_cmd_pkg::MOD_FOUR_WIRE && !blk[0];
        s_d.phase = scan_cmd_pkg::PH_IDLE;
      end
      scan_cmd_pkg::PH_CLEAR: begin
        mem_we = 1'b1;
        mem_waddr = s_q.walk;
        mem_wdata = 8'h00;
        s_d.latch.stb = 1'b1;
        s_d.latch.block = s_q.walk;
        s_d.latch.bits = 8'h00;
        s_d.walk = s_q.walk + 7'h01;
        if (s_q.walk == scan_cmd_pkg::BLOCK_LAST) begin
          s_d.walk = 7'h00;
          s_d.phase = scan_cmd_pkg::PH_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      s_q <= '0;
      s_q.phase <= scan_cmd_pkg::PH_CLEAR;
      s_q.lower <= scan_cmd_pkg::LOWER_RESET;
      s_q.upper <= scan_cmd_pkg::UPPER_RESET;
      s_q.blank <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Listener only: there is no path that drives the IEEE-488 data lines
  assign SCAN_OUT = s_q.scan;
  assign LATCH_OUT = s_q.latch;
  assign DISPLAY_BCD = s_q.bcd;
  assign DISPLAY_BLANK = s_q.blank;
  assign ERR_SHOW = s_q.err;
  assign REMOTE_LAMP = s_q.remote;
  assign KEYPAD_LOCK = s_q.lockout;
  assign LISTENING = s_q.listen;

endmodule
